// ==== hdl/ext_sense_detect.sv ====
/*
  request detector for one external interrupt input.
  assumes the pin is already synchronised to clk_i.
*/
`timescale 1ns/10ps
module ext_sense_detect
  import ppic_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pin and selection
  input wire logic pin_i,
  input wire logic level_i,
  input wire logic low_i,
  // request
  output logic req_o
);

  logic prev_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= pin_i;
    end
  end

  // rising, falling, high level, low level
  always_comb begin
    case ({level_i, low_i})
      2'b00: req_o = pin_i & ~prev_reg;
      2'b01: req_o = ~pin_i & prev_reg;
      2'b10: req_o = pin_i;
      default: req_o = ~pin_i;
    endcase
  end

endmodule // ext_sense_detect

// ==== hdl/ppic_ctrl.sv ====
/*
  programmable priority interrupt controller: pending, mask, priority map,
  vector selection and in-service tracking, on a classic wishbone slave.
  assumes the core pulses vec_ack_i while vec_o.req is high and pulses
  interrupt_return_op_i on interrupt return; peripheral requests are on clk_i.
*/
`timescale 1ns/10ps
// Operation
// R01: level and polarity bits pick sense mode
// R02: vectoring sets in-service bit of programmed slot
// R03: return clears in-service bit of exited slot
// R04: four-bit slot fields hold source codes
// R05: map only used once enable bit set
// R06: software fills empty slots with all ones
// R07: vector address follows assigned slot
// R08: default low priorities; mask gates per slot
// R09: enable clear means fixed default priorities
// R10: request sets pending; vectoring clears it
// R11: software pending set acts like hardware; lost if vectoring clears that source in the same cycle
// R12: highest enabled pending slot wins, fifteen top
module ppic_ctrl
  import ppic_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire wb_req_t wb_i,
  output wb_rsp_t wb_o,
  // interrupt sources
  input wire periph_req_t periph_i,
  input wire logic [3:0] ext_pin_i,
  // core handshake
  input wire logic vec_ack_i,
  input wire logic interrupt_return_op_i,
  output vec_out_t vec_o,
  output logic [1:0] ext_hi_req_o,
  // controller event interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [7:0] mask_lo_reg;
  logic [7:0] mask_hi_reg;
  logic [7:0] pend_reg;
  logic [7:0] sense_reg;
  logic pen_reg;
  logic [15:0] map_reg [4];
  logic [15:0] in_serv_reg;
  logic [2:0] ev_stat_reg;
  logic [2:0] ev_mask_reg;
  logic irq_reg;
  logic vec_req_reg;
  logic [3:0] vec_slot_reg;
  logic [2:0] vec_src_reg;
  logic [23:0] vec_addr_reg;
  logic [1:0] ext_hi_reg;
  logic [3:0] ext_meta_reg;
  logic [3:0] ext_sync_reg;
  logic [3:0] ext_req;
  logic acc;
  logic [13:0] idx;
  logic wr_lo;
  logic wr_hi;
  logic take;
  logic [7:0] hw_set;
  logic [15:0] mask16;
  logic [3:0] slot_of [8];
  logic [7:0] found;
  logic best_valid;
  logic [3:0] best_slot;
  logic [2:0] best_src;
  logic [3:0] interrupt_return_op_top;
  logic [15:0] in_set;
  logic [15:0] in_clr;
  logic [2:0] ev_now;

  assign acc = wb_i.cyc & wb_i.stb & ~ack_reg;
  assign idx = wb_i.adr[15:2];
  assign wr_lo = acc & wb_i.we & wb_i.sel[0];
  assign wr_hi = acc & wb_i.we & wb_i.sel[1];
  assign take = vec_ack_i & vec_req_reg;
  assign mask16 = {mask_hi_reg, mask_lo_reg};
  assign wb_o = '{ack: ack_reg, dat: rdat_reg};
  assign vec_o = '{req: vec_req_reg, slot: vec_slot_reg, src: vec_src_reg,
                   addr: vec_addr_reg};
  assign ext_hi_req_o = ext_hi_reg;
  assign irq_o = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // external inputs: two-flop synchroniser, then sense detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_meta_reg <= 4'h0;
      ext_sync_reg <= 4'h0;
    end else begin
      ext_meta_reg <= ext_pin_i;
      ext_sync_reg <= ext_meta_reg;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_sense
    ext_sense_detect u_det (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(ext_sync_reg[i]),
      .level_i(sense_reg[SENSE_LEV_LSB + i]), // [R01]
      .low_i(sense_reg[SENSE_POL_LSB + i]), // [R01]
      .req_o(ext_req[i])
    );
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_hi_reg <= 2'h0;
    end else begin
      ext_hi_reg <= ext_req[3:2];
    end
  end

  // hardware requests by default priority code
  assign hw_set = {periph_i.event_ch0, periph_i.ser_rx, periph_i.ser_tx,
                   ext_req[1], ext_req[0], 1'b0, periph_i.timer2,
                   periph_i.timer1}; // [R08]

  ////////////////////////////////////////////////////////////////////////
  // slot of each source and selection of the winner
  always_comb begin
    for (int s = 0; s < 8; s++) begin
      slot_of[s] = {1'b0, 3'(s)}; // [R09]
      found[s] = 1'b1;
      if (pen_reg) begin // [R05]
        found[s] = 1'b0;
        for (int k = 0; k < 16; k++) begin
          if (map_reg[k / 4][(k % 4) * 4 +: 4] == {1'b0, 3'(s)}) begin // [R04]
            slot_of[s] = 4'(k);
            found[s] = 1'b1;
          end
        end
      end
    end
  end

  always_comb begin
    best_valid = 1'b0;
    best_slot = 4'h0;
    best_src = 3'h0;
    for (int s = 0; s < 8; s++) begin
      if (pend_reg[s] && found[s] && mask16[slot_of[s]] && // [R08]
          (!best_valid || slot_of[s] > best_slot)) begin // [R12]
        best_valid = 1'b1;
        best_slot = slot_of[s];
        best_src = 3'(s);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_req_reg <= 1'b0;
      vec_slot_reg <= 4'h0;
      vec_src_reg <= 3'h0;
      vec_addr_reg <= VEC_BASE;
    end else begin
      vec_req_reg <= best_valid & ~take;
      vec_slot_reg <= best_slot;
      vec_src_reg <= best_src;
      vec_addr_reg <= VEC_BASE + {19'h0, best_slot, 1'b0}; // [R07]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pending bits: hardware and software set, vectoring clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= RST_PEND;
    end else begin
      pend_reg <= ((wr_lo && idx == IDX_PEND) ? wb_i.dat[7:0] : pend_reg) // [R11]
                  & ~(take ? (8'h01 << vec_src_reg) : 8'h00) // [R10]
                  | hw_set; // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // in-service tracking
  always_comb begin
    interrupt_return_op_top = 4'h0;
    for (int k = 0; k < 16; k++) begin
      if (in_serv_reg[k]) begin
        interrupt_return_op_top = 4'(k);
      end
    end
    in_set = take ? (16'h0001 << vec_slot_reg) : 16'h0000; // [R02]
    in_clr = (interrupt_return_op_i && in_serv_reg != 16'h0000) ? (16'h0001 << interrupt_return_op_top)
                                                 : 16'h0000; // [R03]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_serv_reg <= RST_INSV;
    end else begin
      in_serv_reg <= (in_serv_reg & ~in_clr) | in_set; // [R02] [R03]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software-written control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_lo_reg <= RST_MASK;
      mask_hi_reg <= RST_MASK;
      sense_reg <= RST_SENSE;
      pen_reg <= 1'b0;
      ev_mask_reg <= RST_EV;
    end else if (wr_lo) begin
      if (idx == IDX_MASK_LO) begin
        mask_lo_reg <= wb_i.dat[7:0];
      end else if (idx == IDX_MASK_HI) begin
        mask_hi_reg <= wb_i.dat[7:0];
      end else if (idx == IDX_SENSE) begin
        sense_reg <= wb_i.dat[7:0]; // [R01]
      end else if (idx == IDX_FIX_PEND) begin
        pen_reg <= wb_i.dat[PEN_BIT]; // [R05]
      end else if (idx == IDX_EV_MASK) begin
        ev_mask_reg <= wb_i.dat[2:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      map_reg[0] <= RST_MAP0;
      map_reg[1] <= RST_MAP1;
      map_reg[2] <= RST_MAP2;
      map_reg[3] <= RST_MAP3;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if ((i == 0 && idx == IDX_MAP0) || (i == 1 && idx == IDX_MAP1) ||
            (i == 2 && idx == IDX_MAP2) || (i == 3 && idx == IDX_MAP3)) begin
          if (wr_lo) begin
            map_reg[i][7:0] <= wb_i.dat[7:0]; // [R04]
          end
          if (wr_hi) begin
            map_reg[i][15:8] <= wb_i.dat[15:8]; // [R04]
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // controller events, write-one-to-clear, set wins
  assign ev_now = {interrupt_return_op_i & (in_serv_reg == 16'h0000), take, |hw_set};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_stat_reg <= RST_EV;
      irq_reg <= 1'b0;
    end else begin
      ev_stat_reg <= (ev_stat_reg & ~((wr_lo && idx == IDX_EV_STAT) ?
                      wb_i.dat[2:0] : 3'h0)) | ev_now;
      irq_reg <= |(ev_stat_reg & ev_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus answer and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg <= acc;
      if (acc) begin
        if (idx == IDX_MASK_LO) begin
          rdat_reg <= {24'h0, mask_lo_reg};
        end else if (idx == IDX_MASK_HI) begin
          rdat_reg <= {24'h0, mask_hi_reg};
        end else if (idx == IDX_PEND) begin
          rdat_reg <= {24'h0, pend_reg};
        end else if (idx == IDX_SENSE) begin
          rdat_reg <= {24'h0, sense_reg};
        end else if (idx == IDX_FIX_PEND) begin
          rdat_reg <= {24'h0, pen_reg, 7'h0};
        end else if (idx == IDX_INSV_MSK) begin
          rdat_reg <= {16'h0, in_serv_reg};
        end else if (idx == IDX_MAP0) begin
          rdat_reg <= {16'h0, map_reg[0]};
        end else if (idx == IDX_MAP1) begin
          rdat_reg <= {16'h0, map_reg[1]};
        end else if (idx == IDX_MAP2) begin
          rdat_reg <= {16'h0, map_reg[2]};
        end else if (idx == IDX_MAP3) begin
          rdat_reg <= {16'h0, map_reg[3]};
        end else if (idx == IDX_EV_STAT) begin
          rdat_reg <= {29'h0, ev_stat_reg};
        end else if (idx == IDX_EV_MASK) begin
          rdat_reg <= {29'h0, ev_mask_reg};
        end else begin
          rdat_reg <= 32'h0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence take_s;
    vec_ack_i && vec_req_reg;
  endsequence

  sequence interrupt_return_op_s;
    interrupt_return_op_i && !take && (in_serv_reg != 16'h0000);
  endsequence

  sequence low_level_s;
    sense_reg[SENSE_LEV_LSB] && sense_reg[SENSE_POL_LSB] && !ext_sync_reg[0];
  endsequence

  ack_one_cycle_a: assert property (ack_reg |=> !ack_reg)
    else $error("bus ack held longer than one cycle");

  low_level_pend_a: assert property ( // [R01]
    low_level_s |=> pend_reg[SRC_EXT0])
    else $error("low level on input 0 did not set pending");

  vec_in_service_a: assert property ( // [R02]
    take_s |=> in_serv_reg[$past(vec_slot_reg)])
    else $error("in-service bit not set for taken slot");

  interrupt_return_op_clears_a: assert property ( // [R03]
    interrupt_return_op_s |=> !in_serv_reg[$past(interrupt_return_op_top)])
    else $error("return did not clear in-service bit");

  map_field_match_a: assert property ( // [R04]
    pen_reg && vec_req_reg && $stable(pen_reg) |->
    map_reg[vec_slot_reg[3:2]][vec_slot_reg[1:0] * 4 +: 4] == {1'b0, vec_src_reg})
    else $error("selected slot field does not hold source code");

  vec_addr_slot_a: assert property ( // [R07]
    vec_req_reg |-> vec_addr_reg == VEC_BASE + {19'h0, vec_slot_reg, 1'b0})
    else $error("vector address does not follow slot");

  fixed_prio_a: assert property ( // [R09]
    !pen_reg && !$past(pen_reg) && vec_req_reg |->
    vec_slot_reg == {1'b0, vec_src_reg})
    else $error("default priority not used while map disabled");

  take_clears_pend_a: assert property ( // [R10]
    take_s ##0 !hw_set[vec_src_reg] ##0 !(wr_lo && idx == IDX_PEND) |=>
    !pend_reg[$past(vec_src_reg)])
    else $error("pending not cleared on vectoring");

  sw_set_pend_a: assert property ( // [R11]
    wr_lo && idx == IDX_PEND && wb_i.dat[SRC_TIMER2] &&
    !(take && vec_src_reg == SRC_TIMER2) |=> pend_reg[SRC_TIMER2])
    else $error("software set of pending lost");

  winner_masked_a: assert property ( // [R08]
    best_valid |-> mask16[best_slot] && pend_reg[best_src])
    else $error("masked or idle source selected");

  interrupt_return_op_empty_ev_a: assert property ( // [R03]
    interrupt_return_op_i && in_serv_reg == 16'h0000 |=> ev_stat_reg[EV_INTERRUPT_RETURN_OP_ERR])
    else $error("return with nothing in service not flagged");

endmodule // ppic_ctrl

// ==== hdl/ppic_pkg.sv ====
/*
  constants, register indices, reset values and carrier types of the
  programmable priority interrupt controller.
  assumes a 32-bit classic wishbone bus with byte addresses; byte address
  of a register is four times its index.
*/
package ppic_pkg;

  // register indices (byte address = index * 4)
  localparam logic [13:0] IDX_MASK_LO = 14'h0008;
  localparam logic [13:0] IDX_PEND = 14'h0009;
  localparam logic [13:0] IDX_MASK_HI = 14'h0013;
  localparam logic [13:0] IDX_EV_STAT = 14'h1f00;
  localparam logic [13:0] IDX_EV_MASK = 14'h1f01;
  localparam logic [13:0] IDX_INSV_FIX = 14'h1fc8;
  localparam logic [13:0] IDX_FIX_PEND = 14'h1fc9;
  localparam logic [13:0] IDX_INSV_MSK = 14'h1fca;
  localparam logic [13:0] IDX_SENSE = 14'h1fcc;
  localparam logic [13:0] IDX_MAP0 = 14'h1fe8;
  localparam logic [13:0] IDX_MAP1 = 14'h1fea;
  localparam logic [13:0] IDX_MAP2 = 14'h1fec;
  localparam logic [13:0] IDX_MAP3 = 14'h1fee;

  // reset values
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_PEND = 8'h00;
  localparam logic [7:0] RST_SENSE = 8'h00;
  localparam logic [15:0] RST_INSV = 16'h0000;
  localparam logic [15:0] RST_MAP0 = 16'h3210;
  localparam logic [15:0] RST_MAP1 = 16'h7654;
  localparam logic [15:0] RST_MAP2 = 16'hba98;
  localparam logic [15:0] RST_MAP3 = 16'hfedc;
  localparam logic [2:0] RST_EV = 3'h0;

  // field positions
  localparam int PEN_BIT = 7;
  localparam int SENSE_LEV_LSB = 4;
  localparam int SENSE_POL_LSB = 0;

  // default priority codes of the maskable low-byte sources
  localparam logic [2:0] SRC_TIMER1 = 3'h0;
  localparam logic [2:0] SRC_TIMER2 = 3'h1;
  localparam logic [2:0] SRC_EXT0 = 3'h3;
  localparam logic [2:0] SRC_EXT1 = 3'h4;

  // event status bits
  localparam int EV_REQ = 0;
  localparam int EV_VEC = 1;
  localparam int EV_INTERRUPT_RETURN_OP_ERR = 2;

  // vector table: base of slot 0 and a stride of two bytes per slot
  localparam logic [23:0] VEC_BASE = 24'hff2020;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic event_ch0;
    logic ser_rx;
    logic ser_tx;
    logic timer2;
    logic timer1;
  } periph_req_t;

  typedef struct packed {
    logic req;
    logic [3:0] slot;
    logic [2:0] src;
    logic [23:0] addr;
  } vec_out_t;

endpackage

// ==== sim/core_model.sv ====
/*
  processor core model: takes offered vectors and issues interrupt returns.
  assumes the bench enables takes and requests returns just after clock edges.
*/
`timescale 1ns/10ps
module core_model
  import ppic_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // controls from the bench
  input wire logic take_i,
  input wire logic [3:0] lag_i,
  input wire logic ret_i,
  // controller side
  input wire vec_out_t vec_i,
  output logic vec_ack_o,
  output logic interrupt_return_op_o,
  output logic [7:0] taken_o
);
  logic [3:0] wait_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // take an offer after lag_i cycles, one pulse per offer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_ack_o <= 1'b0;
      wait_reg <= 4'h0;
      taken_o <= 8'h00;
    end else begin
      vec_ack_o <= 1'b0;
      if (take_i && vec_i.req && !vec_ack_o) begin
        if (wait_reg == lag_i) begin
          vec_ack_o <= 1'b1;
          taken_o <= taken_o + 8'h01;
          wait_reg <= 4'h0;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
  // return pulse one cycle after the bench asks
  always_ff @(posedge clk_i) begin
    interrupt_return_op_o <= rst_i ? 1'b0 : ret_i;
  end
endmodule // core_model

// ==== sim/tb_programmable_priority_interrupt_control.sv ====
/*
  self-checking bench of the priority interrupt controller.
  assumes ppic_ctrl and core_model are compiled before it.
*/
`timescale 1ns/10ps
module tb_programmable_priority_interrupt_control
  import ppic_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t wb_req = '0;
  wb_rsp_t wb_rsp;
  periph_req_t periph = '0;
  logic [3:0] ext_pin = 4'h0;
  logic take = 1'b0;
  logic ret = 1'b0;
  logic [3:0] lag = 4'h0;
  logic vec_ack, interrupt_return_op, irq;
  logic [1:0] ext_hi;
  logic [7:0] taken;
  vec_out_t vec;
  logic [31:0] q;
  int errors = 0;
  int comparisons = 0;
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  ppic_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req), .wb_o(wb_rsp),
    .periph_i(periph), .ext_pin_i(ext_pin), .vec_ack_i(vec_ack), .interrupt_return_op_i(interrupt_return_op),
    .vec_o(vec), .ext_hi_req_o(ext_hi), .irq_o(irq));
  core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .take_i(take), .lag_i(lag),
    .ret_i(ret), .vec_i(vec), .vec_ack_o(vec_ack), .interrupt_return_op_o(interrupt_return_op), .taken_o(taken));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [13:0] i, input logic [15:0] d);
    int n;
    @(posedge clk_i);
    wb_req <= '{1'b1, 1'b1, we, {i, 2'b00}, 4'h3, {16'h0000, d}};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    q = wb_rsp.dat;
    wb_req <= '0;
    if (n >= 50) begin
      errors++;
      wrap_up;
    end
  endtask
  task automatic rd(input logic [13:0] i, input logic [31:0] e, input string nm);
    wb(1'b0, i, 16'h0000);
    chk(nm, e, q);
  endtask
  task automatic ret_pulse;
    @(posedge clk_i);
    ret <= 1'b1;
    @(posedge clk_i);
    ret <= 1'b0;
    cyc(3);
  endtask
  task automatic take_vec(input logic [3:0] s, input logic [2:0] c);
    int n;
    logic [7:0] t0;
    n = 0;
    while (vec.req !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      errors++;
      wrap_up;
    end
    chk("vector slot", 32'(s), 32'(vec.slot));
    chk("vector source", 32'(c), 32'(vec.src));
    chk("vector address", 32'(VEC_BASE + {19'h0, s, 1'b0}), 32'(vec.addr));
    t0 = taken;
    take <= 1'b1;
    n = 0;
    while (taken === t0 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    take <= 1'b0;
    cyc(2);
    if (n >= 50) begin
      errors++;
      wrap_up;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [15:0] maps [4] = '{16'h3210, 16'h7654, 16'hba98, 16'hfedc};
    rd(IDX_MASK_LO, 32'h0, "enable mask");
    rd(IDX_INSV_MSK, 32'h0, "in service");
    rd(IDX_SENSE, 32'h0, "sense control");
    rd(IDX_FIX_PEND, 32'h0, "priority enable");
    for (int k = 0; k < 4; k++)
      rd(IDX_MAP0 + 14'(2 * k), 32'(maps[k]), "priority map");
    rd(14'h0001, 32'h0, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_default;
    wb(1'b1, IDX_MASK_LO, 16'h0081);
    wb(1'b1, IDX_PEND, 16'h0002);
    cyc(4);
    chk("masked offer", 32'h0, 32'(vec.req));
    wb(1'b1, IDX_PEND, 16'h0081);
    take_vec(4'h7, 3'h7);
    rd(IDX_INSV_MSK, 32'h0080, "in service");
    rd(IDX_PEND, 32'h01, "pending");
    take_vec(4'h0, 3'h0);
    rd(IDX_INSV_MSK, 32'h0081, "in service");
    ret_pulse;
    rd(IDX_INSV_MSK, 32'h0001, "in service");
    ret_pulse;
    rd(IDX_INSV_MSK, 32'h0000, "in service");
    wb(1'b1, IDX_PEND, 16'h0000);
    $display("test default done");
  endtask
  task automatic t_remap;
    lag <= 4'h3;
    wb(1'b1, IDX_MAP0, 16'hffff);
    wb(1'b1, IDX_MAP1, 16'hffff);
    wb(1'b1, IDX_MAP2, 16'hffff);
    wb(1'b1, IDX_MAP3, 16'hfff0);
    wb(1'b1, IDX_FIX_PEND, 16'h0080);
    wb(1'b1, IDX_MASK_LO, 16'h0001);
    @(posedge clk_i);
    periph.timer1 <= 1'b1;
    @(posedge clk_i);
    periph.timer1 <= 1'b0;
    cyc(4);
    chk("offer at old slot", 32'h0, 32'(vec.req));
    wb(1'b1, IDX_MASK_HI, 16'h0010);
    take_vec(4'hc, SRC_TIMER1);
    rd(IDX_INSV_MSK, 32'h1000, "in service");
    rd(IDX_PEND, 32'h0, "pending");
    ret_pulse;
    rd(IDX_INSV_MSK, 32'h0, "in service");
    lag <= 4'h0;
    $display("test remap done");
  endtask
  task automatic t_sense;
    logic [1:0] m;
    wb(1'b1, IDX_FIX_PEND, 16'h0000);
    wb(1'b1, IDX_MASK_LO, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      m = 2'(k);
      wb(1'b1, IDX_SENSE, {11'h000, m[1], 3'h0, m[0]});
      ext_pin[0] <= m[0];
      cyc(6);
      wb(1'b1, IDX_PEND, 16'h0000);
      rd(IDX_PEND, 32'h0, "idle pending");
      ext_pin[0] <= ~m[0];
      cyc(6);
      rd(IDX_PEND, 32'h08, "sensed pending");
    end
    ext_pin[0] <= 1'b1;
    cyc(6);
    wb(1'b1, IDX_SENSE, 16'h0040);
    chk("external high idle", 32'h0, 32'(ext_hi));
    ext_pin[2] <= 1'b1;
    cyc(6);
    chk("external high level", 32'h1, 32'(ext_hi));
    ext_pin[2] <= 1'b0;
    cyc(6);
    chk("external high released", 32'h0, 32'(ext_hi));
    wb(1'b1, IDX_SENSE, 16'h0000);
    wb(1'b1, IDX_PEND, 16'h0000);
    $display("test sense done");
  endtask
  task automatic t_irq;
    wb(1'b1, IDX_EV_MASK, 16'h0000);
    wb(1'b1, IDX_EV_STAT, 16'h0007);
    ret_pulse;
    rd(IDX_EV_STAT, 32'h04, "event status");
    chk("masked irq", 32'h0, 32'(irq));
    wb(1'b1, IDX_EV_MASK, 16'h0004);
    cyc(2);
    chk("raised irq", 32'h1, 32'(irq));
    wb(1'b1, IDX_EV_STAT, 16'h0004);
    cyc(2);
    chk("cleared irq", 32'h0, 32'(irq));
    $display("test irq done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_default;
    t_remap;
    t_sense;
    t_irq;
    wrap_up;
  end
endmodule // tb_programmable_priority_interrupt_control
